// ---- common/dlt_pkg.sv ----
// shared constants and types for the dual legacy counter/timer block
`default_nettype none

package dlt_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_RUN = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CLKSEL = 8'h08;
  localparam logic [7:0] OFF_EXTCFG = 8'h0c;
  localparam logic [7:0] OFF_IRQEN = 8'h10;
  localparam logic [7:0] OFF_LO0 = 8'h14;
  localparam logic [7:0] OFF_HI0 = 8'h18;
  localparam logic [7:0] OFF_LO1 = 8'h1c;
  localparam logic [7:0] OFF_HI1 = 8'h20;

  // ==========================================================
  // field positions
  localparam int RUN_OVF1 = 7;
  localparam int RUN_RUN1 = 6;
  localparam int RUN_OVF0 = 5;
  localparam int RUN_RUN0 = 4;
  localparam int MODE_GATE1 = 7;
  localparam int MODE_SRC1 = 6;
  localparam int MODE_M1 = 4;
  localparam int MODE_GATE_ENABLE_ZERO = 3;
  localparam int MODE_SRC0 = 2;
  localparam int MODE_M0 = 0;
  localparam int CLK_PICK1 = 4;
  localparam int CLK_PICK0 = 3;
  localparam int CLK_SCA = 0;
  localparam int EXT_POL0 = 0;
  localparam int EXT_POL1 = 1;
  localparam int IRQ_EN0 = 1;
  localparam int IRQ_EN1 = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PAIR = 2'h0;

  // ==========================================================
  // prescale choices and divisors
  localparam logic [1:0] SCA_DIV12 = 2'h0;
  localparam logic [1:0] SCA_DIV4 = 2'h1;
  localparam logic [1:0] SCA_DIV48 = 2'h2;
  localparam logic [1:0] SCA_EXT8 = 2'h3;
  localparam int DIV_A = 12;
  localparam int DIV_B = 4;
  localparam int DIV_C = 48;
  localparam int DIV_EXT = 8;

  // ==========================================================
  // counting modes
  typedef enum logic [1:0] {
    DLT_M13 = 2'b00,
    DLT_M16 = 2'b01,
    DLT_M8R = 2'b10,
    DLT_MOFF = 2'b11
  } dlt_mode_t;

endpackage : dlt_pkg

`default_nettype wire

// ---- common/dlt_tmr_if.sv ----
// control and status bundle between the top and one timer channel
`timescale 1ns/1ps
`default_nettype none

interface dlt_tmr_if;
  logic en;
  logic tick;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  dlt_pkg::dlt_mode_t mode;
  logic [7:0] lo;
  logic [7:0] hi;
  logic ovf;

  modport ctl (output en, tick, wr_lo, wr_hi, wdata, mode, input lo, hi, ovf);
  modport tmr (input en, tick, wr_lo, wr_hi, wdata, mode, output lo, hi, ovf);
endinterface : dlt_tmr_if

`default_nettype wire

// ---- rtl/dlt_sync.sv ----
// two-stage pin synchroniser with one extra stage for edge detection
`timescale 1ns/1ps
`default_nettype none

module dlt_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // asynchronous pins in
  input wire logic [W-1:0] din,
  // synchronised level and its previous sample
  output logic [W-1:0] dout,
  output logic [W-1:0] dprev
);

  // ==========================================================
  // checks
  if (W < 1) begin : g_bad_w
    $error("dlt_sync: width must be at least one");
  end

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // s1 feeds only s2; edges are found on s2 against s3
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign dout = s2_r;
  assign dprev = s3_r;

endmodule : dlt_sync

`default_nettype wire

// ---- rtl/dlt_tmr.sv ----
// one counter/timer channel: count bytes, mode arithmetic, overflow
`timescale 1ns/1ps
`default_nettype none

module dlt_tmr (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control from the top
  dlt_tmr_if.tmr tif
);
  import dlt_pkg::*;

  logic [7:0] lo_r;
  logic [7:0] lo_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  logic ovf;
  wire logic step;
  wire logic [12:0] c13;
  wire logic [15:0] c16;
  wire logic [12:0] n13;
  wire logic [15:0] n16;
  wire logic wrap8;

  // ==========================================================
  // count arithmetic
  // a write in the same cycle drops the increment entirely
  assign step = tif.en & tif.tick & ~(tif.wr_lo | tif.wr_hi); // R22
  assign c13 = {hi_r, lo_r[4:0]}; // R4
  assign c16 = {hi_r, lo_r}; // R1
  assign n13 = c13 + 13'h0001;
  assign n16 = c16 + 16'h0001;
  assign wrap8 = (lo_r == 8'hff);

  // next count per mode; software write overrides last
  always_comb begin
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    ovf = 1'b0;
    if (step) begin
      case (tif.mode) // R3
        DLT_M13: begin
          lo_nxt = {lo_r[7:5], n13[4:0]}; // R5
          hi_nxt = n13[12:5]; // R4
          ovf = (c13 == 13'h1fff); // R6
        end
        DLT_M16: begin
          lo_nxt = n16[7:0]; // R7
          hi_nxt = n16[15:8];
          ovf = (c16 == 16'hffff);
        end
        DLT_M8R: begin
          lo_nxt = wrap8 ? hi_r : lo_r + 8'h01; // R8
          ovf = wrap8;
        end
        default: begin
          ovf = 1'b0;
        end
      endcase
    end
    if (tif.wr_lo) begin
      lo_nxt = tif.wdata; // R22
    end
    if (tif.wr_hi) begin
      hi_nxt = tif.wdata; // R22
    end
  end

  // count bytes; the run bit never touches them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lo_r <= RST_BYTE;
      hi_r <= RST_BYTE;
    end else begin
      lo_r <= lo_nxt; // R16
      hi_r <= hi_nxt;
    end
  end

  assign tif.lo = lo_r;
  assign tif.hi = hi_r;
  assign tif.ovf = ovf;

  // ==========================================================
  // checks
  sequence s_wrap8;
    step && tif.mode == DLT_M8R && lo_r == 8'hff;
  endsequence

  sequence s_wrap13;
    step && tif.mode == DLT_M13 && c13 == 13'h1fff;
  endsequence

  reload_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    s_wrap8 |-> ovf ##1 (lo_r == $past(hi_r) && hi_r == $past(hi_r)))
    else $error("reload did not copy high byte");

  wrap_13_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    s_wrap13 |-> ovf ##1 (c13 == 13'h0000))
    else $error("13-bit wrap wrong");

  count_16_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    (step && tif.mode == DLT_M16) |=> (c16 == $past(c16) + 16'h0001))
    else $error("16-bit step wrong");

  upper_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
    (step && tif.mode == DLT_M13) |=> (lo_r[7:5] == $past(lo_r[7:5])))
    else $error("13-bit mode touched upper low bits");

  write_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R22
    (tif.wr_lo && tif.en && tif.tick) |=> (lo_r == $past(tif.wdata)))
    else $error("write lost against increment");

  idle_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R14
    (!tif.en && !tif.wr_lo && !tif.wr_hi) |=> $stable(c16) && !$past(ovf))
    else $error("count moved while disabled");

endmodule : dlt_tmr

`default_nettype wire

// ---- rtl/dlt_top.sv ----
// dual counter/timer: apb registers, clock sources, gating, flags
//
// Overview of operation
// [R1] sixteen-bit count read as two bytes
// [R2] each timer has its own mode
// [R3] mode 00 13-bit, 01 16-bit, 10 reload
// [R4] 13-bit: high byte plus five low bits
// [R5] upper three low bits undefined, ignored
// [R6] 13-bit wrap sets overflow flag
// [R7] 16-bit mode uses all bits
// [R8] reload mode: low counts, high reloads
// [R9] software preloads low byte before reload run
// [R10] event source counts falling pin edges
// [R11] pin sampled, levels held two cycles
// [R12] clock pick: system clock or prescaled
// [R13] six clock sources per timer
// [R14] run and gate decide counting
// [R15] gate polarity is configurable
// [R16] run bit keeps the count
// [R17] software loads count before running
// [R18] timer one mirrors timer zero
// [R19] request passes only when enabled
// [R20] flag clears by zero write or vector
// [R21] pins synchronised, edge by sample compare
// [R22] byte write beats same-cycle increment
`timescale 1ns/1ps
`default_nettype none

module dlt_top #(
  parameter int P_DIV_A = dlt_pkg::DIV_A,
  parameter int P_DIV_B = dlt_pkg::DIV_B,
  parameter int P_DIV_C = dlt_pkg::DIV_C,
  parameter int P_DIV_EXT = dlt_pkg::DIV_EXT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // apb slave
  input wire logic [dlt_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dlt_pkg::DATA_W-1:0] pwdata,
  output logic [dlt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic event_pin_zero,
  input wire logic event_pin_one,
  input wire logic gate_input_zero,
  input wire logic gate_input_one,
  input wire logic ext_osc_pin,
  // interrupt requests and vector acknowledges
  output logic irq_req_zero,
  output logic irq_req_one,
  input wire logic irq_ack_zero,
  input wire logic irq_ack_one
);
  import dlt_pkg::*;

  // ==========================================================
  // checks
  if (P_DIV_A < 2 || P_DIV_A > 64 || P_DIV_B < 2 || P_DIV_B > 64 ||
      P_DIV_C < 2 || P_DIV_C > 64) begin : g_bad_div
    $error("dlt_top: prescale divisors must lie in 2..64");
  end
  if (P_DIV_EXT < 2 || P_DIV_EXT > 8) begin : g_bad_ext
    $error("dlt_top: external divisor must lie in 2..8");
  end

  // ==========================================================
  // helpers
  // gate input counts as active when it matches the polarity bit
  function automatic logic gate_act(input logic lvl, input logic pol);
    gate_act = (lvl == pol); // R15
  endfunction

  // one increment source out of event, system clock or prescaler
  function automatic logic pick_tick(input logic src, input logic pick,
                                     input logic evt, input logic pre);
    pick_tick = src ? evt : (pick ? 1'b1 : pre); // R10 R12
  endfunction

  // ==========================================================
  // state
  logic run0_r;
  logic run1_r;
  logic flag0_r;
  logic flag1_r;
  logic [7:0] mode_r;
  logic [1:0] pick_r;
  logic [1:0] sca_r;
  logic [1:0] pol_r;
  logic [1:0] irqen_r;
  logic [DATA_W-1:0] prdata_r;
  logic pslverr_r;
  logic [7:0] rd_data;
  logic rd_hit;
  logic [5:0] pre_r [3];
  logic [2:0] pre_tick;
  logic [2:0] ext_cnt_r;
  logic [4:0] pin_s;
  logic [4:0] pin_p;

  dlt_tmr_if tif0 ();
  dlt_tmr_if tif1 ();

  // ==========================================================
  // pin synchronisers
  // order: ext clock, gate1, gate_enable_zero, event1, event0
  dlt_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .din({ext_osc_pin, gate_input_one, gate_input_zero, event_pin_one, event_pin_zero}),
    .dout(pin_s),
    .dprev(pin_p)
  ); // R21 R11

  wire logic fall0 = pin_p[0] & ~pin_s[0]; // R21
  wire logic fall1 = pin_p[1] & ~pin_s[1];
  wire logic ext_rise = ~pin_p[4] & pin_s[4];

  // ==========================================================
  // prescaler: three system-clock dividers and one external
  localparam int DIVS [3] = '{P_DIV_A, P_DIV_B, P_DIV_C};

  for (genvar g = 0; g < 3; g++) begin : g_pre
    assign pre_tick[g] = (pre_r[g] == 6'(DIVS[g] - 1));
    // free running so every timer sees the same phase
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        pre_r[g] <= 6'h00;
      end else begin
        pre_r[g] <= pre_tick[g] ? 6'h00 : pre_r[g] + 6'h01;
      end
    end
  end

  wire logic ext_tick = ext_rise & (ext_cnt_r == 3'(P_DIV_EXT - 1));

  // external clock only as fast as the synchroniser allows
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_cnt_r <= 3'h0;
    end else if (ext_rise) begin
      ext_cnt_r <= ext_tick ? 3'h0 : ext_cnt_r + 3'h1;
    end
  end

  // shared scale field chooses one of four prescaled ticks
  wire logic sca_tick = (sca_r == SCA_DIV12) ? pre_tick[0] :
                        (sca_r == SCA_DIV4) ? pre_tick[1] :
                        (sca_r == SCA_DIV48) ? pre_tick[2] : ext_tick; // R13

  // ==========================================================
  // apb decode
  wire logic setup = psel & ~penable;
  wire logic wr = psel & penable & pwrite;
  wire logic [7:0] wd = pwdata[7:0];
  wire logic sel_run = (paddr == OFF_RUN);
  wire logic sel_mode = (paddr == OFF_MODE);
  wire logic sel_clk = (paddr == OFF_CLKSEL);
  wire logic sel_ext = (paddr == OFF_EXTCFG);
  wire logic sel_irq = (paddr == OFF_IRQEN);
  wire logic sel_lo0 = (paddr == OFF_LO0);
  wire logic sel_hi0 = (paddr == OFF_HI0);
  wire logic sel_lo1 = (paddr == OFF_LO1);
  wire logic sel_hi1 = (paddr == OFF_HI1);
  wire logic wr_run = wr & sel_run;

  // read mux; reserved bits read zero
  always_comb begin
    rd_data = 8'h00;
    rd_hit = 1'b1;
    case (1'b1)
      sel_run: begin
        rd_data[RUN_OVF1] = flag1_r;
        rd_data[RUN_RUN1] = run1_r;
        rd_data[RUN_OVF0] = flag0_r;
        rd_data[RUN_RUN0] = run0_r;
      end
      sel_mode: rd_data = mode_r;
      sel_clk: begin
        rd_data[CLK_PICK1] = pick_r[1];
        rd_data[CLK_PICK0] = pick_r[0];
        rd_data[CLK_SCA+1:CLK_SCA] = sca_r;
      end
      sel_ext: begin
        rd_data[EXT_POL0] = pol_r[0];
        rd_data[EXT_POL1] = pol_r[1];
      end
      sel_irq: begin
        rd_data[IRQ_EN0] = irqen_r[0];
        rd_data[IRQ_EN1] = irqen_r[1];
      end
      sel_lo0: rd_data = tif0.lo; // R1 R5
      sel_hi0: rd_data = tif0.hi;
      sel_lo1: rd_data = tif1.lo;
      sel_hi1: rd_data = tif1.hi;
      default: rd_hit = 1'b0;
    endcase
  end

  // read data captured in setup, answered in the first access cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= {24'h000000, rd_data};
      pslverr_r <= ~rd_hit;
    end
  end

  assign pready = psel & penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run0_r <= 1'b0;
      run1_r <= 1'b0;
      mode_r <= RST_BYTE;
      pick_r <= RST_PAIR;
      sca_r <= RST_PAIR;
      pol_r <= RST_PAIR;
      irqen_r <= RST_PAIR;
    end else if (wr) begin
      if (sel_run) begin
        run0_r <= wd[RUN_RUN0]; // R16
        run1_r <= wd[RUN_RUN1];
      end
      if (sel_mode) begin
        mode_r <= wd; // R2
      end
      if (sel_clk) begin
        pick_r <= {wd[CLK_PICK1], wd[CLK_PICK0]};
        sca_r <= wd[CLK_SCA+1:CLK_SCA];
      end
      if (sel_ext) begin
        pol_r <= {wd[EXT_POL1], wd[EXT_POL0]};
      end
      if (sel_irq) begin
        irqen_r <= {wd[IRQ_EN1], wd[IRQ_EN0]};
      end
    end
  end

  // ==========================================================
  // overflow flags: hardware set beats any clear
  wire logic clr0 = (wr_run & ~wd[RUN_OVF0]) | irq_ack_zero; // R20
  wire logic clr1 = (wr_run & ~wd[RUN_OVF1]) | irq_ack_one;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag0_r <= 1'b0;
      flag1_r <= 1'b0;
    end else begin
      flag0_r <= tif0.ovf | (flag0_r & ~clr0); // R6 R20
      flag1_r <= tif1.ovf | (flag1_r & ~clr1); // R18
    end
  end

  assign irq_req_zero = flag0_r & irqen_r[0]; // R19
  assign irq_req_one = flag1_r & irqen_r[1];

  // ==========================================================
  // channel control; timer one uses its own bits and pins
  wire logic gact0 = gate_act(pin_s[2], pol_r[0]);
  wire logic gact1 = gate_act(pin_s[3], pol_r[1]);

  assign tif0.en = run0_r & (~mode_r[MODE_GATE_ENABLE_ZERO] | gact0); // R14
  assign tif1.en = run1_r & (~mode_r[MODE_GATE1] | gact1); // R18
  assign tif0.tick = pick_tick(mode_r[MODE_SRC0], pick_r[0], fall0, sca_tick);
  assign tif1.tick = pick_tick(mode_r[MODE_SRC1], pick_r[1], fall1, sca_tick);
  assign tif0.mode = dlt_mode_t'(mode_r[MODE_M0+1:MODE_M0]); // R2
  assign tif1.mode = dlt_mode_t'(mode_r[MODE_M1+1:MODE_M1]);
  assign tif0.wr_lo = wr & sel_lo0;
  assign tif0.wr_hi = wr & sel_hi0;
  assign tif1.wr_lo = wr & sel_lo1;
  assign tif1.wr_hi = wr & sel_hi1;
  assign tif0.wdata = wd;
  assign tif1.wdata = wd;

  dlt_tmr u_tmr0 (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tif(tif0)
  );

  dlt_tmr u_tmr1 (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tif(tif1)
  );

  // ==========================================================
  // checks
  // a mask write in the overflow cycle may legally drop the request
  sequence s_ovf_enabled;
    tif0.ovf && irqen_r[0] && !irq_ack_zero && !(wr && sel_irq);
  endsequence

  flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    tif0.ovf |=> flag0_r)
    else $error("overflow did not set flag");

  irq_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R19
    s_ovf_enabled |=> irq_req_zero)
    else $error("enabled overflow gave no request");

  irq_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R19
    (wr && sel_irq && !wd[IRQ_EN1]) |=> !irq_req_one)
    else $error("masked request passed");

  ack_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R20
    (irq_ack_zero && !tif0.ovf) |=> !flag0_r)
    else $error("vector did not clear flag");

  gate_block_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R14
    (mode_r[MODE_GATE1] && !gact1 && !tif1.wr_lo && !tif1.wr_hi) |=> $stable({tif1.hi, tif1.lo}))
    else $error("gated timer counted");

  event_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
    (mode_r[MODE_SRC0] && !pin_s[0] && pin_p[0]) |-> tif0.tick ##1 !tif0.tick)
    else $error("event edge not one tick");

  sys_pick_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // R12
    (!mode_r[MODE_SRC1] && pick_r[1]) |-> tif1.tick)
    else $error("system clock pick not every cycle");

  apb_once_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (psel && !penable) |=> (penable |-> pready))
    else $error("access phase not answered at once");

endmodule : dlt_top

`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the dual counter/timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin fail_count++; $display("ERROR %0t: got %h exp %h", $time, g, x); end end

module tb_top;
  import dlt_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ev = 2'b11;
  logic [1:0] gt = 2'b00;
  logic [1:0] ack = 2'b00;
  logic [1:0] irq;
  logic ext_osc = 1'b0;
  logic [7:0] run_sh, mode_sh, clk_sh, pol_sh, irq_sh;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  dlt_top u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_pin_zero(ev[0]), .event_pin_one(ev[1]), .gate_input_zero(gt[0]),
    .gate_input_one(gt[1]), .ext_osc_pin(ext_osc), .irq_req_zero(irq[0]),
    .irq_req_one(irq[1]), .irq_ack_zero(ack[0]), .irq_ack_one(ack[1])
  );

  // ==========================================================
  // clock, slow external oscillator, hang guard
  always #10 clk_sys = ~clk_sys;

  // ext clock of eight system cycles, well under the quarter-rate limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ext_osc <= cyc[2];
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end

  // ==========================================================
  // closing report
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // apb master: hold the request until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("ERROR %0t: no pready", $time);
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd8(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 8'h00, r, e);
    `CHK(r[31:8], 24'h0)
    v = r[7:0];
  endtask : rd8

  // ==========================================================
  // timer helpers; flag bits written as one keep their value
  task automatic set_run(input logic t, input logic v);
    run_sh[4 + 2 * t] = v;
    wr(OFF_RUN, run_sh | 8'ha0);
  endtask : set_run

  task automatic cfg(input logic t, input logic [1:0] m, input logic src, input logic gte, input logic pk);
    mode_sh[4 * t +: 4] = {gte, src, m};
    wr(OFF_MODE, mode_sh);
    clk_sh[3 + t] = pk;
    wr(OFF_CLKSEL, clk_sh);
  endtask : cfg

  task automatic load(input logic t, input logic [7:0] hi, input logic [7:0] lo);
    wr(OFF_HI0 + {4'h0, t, 3'h0}, hi);
    wr(OFF_LO0 + {4'h0, t, 3'h0}, lo);
  endtask : load

  task automatic run_for(input logic t, input int n);
    set_run(t, 1'b1);
    repeat (n) @(posedge clk_sys);
    set_run(t, 1'b0);
  endtask : run_for

  task automatic rd_cnt(input logic t, output logic [7:0] hi, output logic [7:0] lo);
    rd8(OFF_HI0 + {4'h0, t, 3'h0}, hi);
    rd8(OFF_LO0 + {4'h0, t, 3'h0}, lo);
  endtask : rd_cnt

  task automatic flag(input logic t, output logic f);
    logic [7:0] v;
    rd8(OFF_RUN, v);
    f = v[5 + 2 * t];
  endtask : flag

  // clearing writes zero to this timer's flag only
  task automatic clr(input logic t);
    wr(OFF_RUN, run_sh | (t ? 8'h20 : 8'h80));
  endtask : clr

  // ==========================================================
  // test sequence
  initial begin
    logic [7:0] h, l;
    logic f;
    logic t;
    logic [31:0] r;
    logic e;
    int dv[4];
    int c;
    int x;
    dv = '{DIV_A, DIV_B, DIV_C, DIV_EXT * 8};
    {run_sh, mode_sh, clk_sh, pol_sh, irq_sh} = '0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    // reset values, then an unmapped address
    for (int i = 0; i < 9; i++) begin
      rd8(8'(4 * i), l);
      `CHK(l, RST_BYTE)
    end
    apb(8'h24, 1'b0, 8'h00, r, e);
    `CHK(e, 1'b1)
    `CHK(r, 32'h0)
    for (int i = 0; i < 2; i++) begin
      t = i[0];
      // 16-bit wrap, request masking, flag cleared by vector
      cfg(t, 2'b01, 1'b0, 1'b0, 1'b1);
      load(t, 8'hff, 8'hf0);
      run_for(t, 40);
      rd_cnt(t, h, l);
      `CHK(h, 8'h00)
      flag(t, f);
      `CHK(f, 1'b1)
      `CHK(irq[t], 1'b0)
      irq_sh[1 + 2 * t] = 1'b1;
      wr(OFF_IRQEN, irq_sh);
      #1;
      `CHK(irq[t], 1'b1)
      @(posedge clk_sys);
      ack[t] <= 1'b1;
      @(posedge clk_sys);
      ack[t] <= 1'b0;
      #1;
      `CHK(irq[t], 1'b0)
      flag(t, f);
      `CHK(f, 1'b0)
      // 13-bit wrap from all ones
      cfg(t, 2'b00, 1'b0, 1'b0, 1'b1);
      load(t, 8'hff, 8'hfc);
      run_for(t, 10);
      rd_cnt(t, h, l);
      `CHK(h, 8'h00)
      `CHK(l[4:0] < 5'd16, 1'b1)
      flag(t, f);
      `CHK(f, 1'b1)
      clr(t);
      flag(t, f);
      `CHK(f, 1'b0)
      // auto-reload: high byte stays, low byte restarts from it
      cfg(t, 2'b10, 1'b0, 1'b0, 1'b1);
      load(t, 8'hf0, 8'hfc);
      run_for(t, 10);
      rd_cnt(t, h, l);
      `CHK(h, 8'hf0)
      `CHK(l[7:4], 4'hf)
      flag(t, f);
      `CHK(f, 1'b1)
      clr(t);
      // five falling edges, levels held three cycles each
      cfg(t, 2'b01, 1'b1, 1'b0, 1'b0);
      load(t, 8'h00, 8'h10);
      set_run(t, 1'b1);
      repeat (5) begin
        @(posedge clk_sys);
        ev[t] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        ev[t] <= 1'b1;
        repeat (2) @(posedge clk_sys);
      end
      repeat (6) @(posedge clk_sys);
      set_run(t, 1'b0);
      rd_cnt(t, h, l);
      `CHK(l, 8'h15)
      run_for(t, 5);
      rd_cnt(t, h, l);
      `CHK(l, 8'h15)
      // gate active high, then active low
      pol_sh[t] = 1'b1;
      wr(OFF_EXTCFG, pol_sh);
      cfg(t, 2'b01, 1'b0, 1'b1, 1'b1);
      load(t, 8'h00, 8'h00);
      run_for(t, 20);
      rd_cnt(t, h, l);
      `CHK(l, 8'h00)
      gt[t] <= 1'b1;
      run_for(t, 20);
      rd_cnt(t, h, l);
      `CHK(l > 8'd10, 1'b1)
      pol_sh[t] = 1'b0;
      wr(OFF_EXTCFG, pol_sh);
      load(t, 8'h00, 8'h00);
      run_for(t, 20);
      rd_cnt(t, h, l);
      `CHK(l, 8'h00)
      gt[t] <= 1'b0;
      run_for(t, 20);
      rd_cnt(t, h, l);
      `CHK(l > 8'd10, 1'b1)
      // every prescale choice over a fixed window
      for (int s = 0; s < 4; s++) begin
        clk_sh[1:0] = 2'(s);
        cfg(t, 2'b01, 1'b0, 1'b0, 1'b0);
        load(t, 8'h00, 8'h00);
        run_for(t, 480);
        rd_cnt(t, h, l);
        c = {h, l};
        x = 480 / dv[s];
        `CHK(c + 2 >= x && c <= x + 2, 1'b1)
      end
      // write landing on a counting cycle wins
      cfg(t, 2'b01, 1'b0, 1'b0, 1'b1);
      load(t, 8'h00, 8'h00);
      set_run(t, 1'b1);
      wr(OFF_LO0 + {4'h0, t, 3'h0}, 8'h55);
      rd8(OFF_LO0 + {4'h0, t, 3'h0}, l);
      `CHK(l >= 8'h55 && l <= 8'h5c, 1'b1)
      set_run(t, 1'b0);
      // mode 11 is not built and must hold the count
      cfg(t, 2'b11, 1'b0, 1'b0, 1'b1);
      load(t, 8'h12, 8'h34);
      run_for(t, 8);
      rd_cnt(t, h, l);
      `CHK({h, l}, 16'h1234)
    end
    close_out();
  end
endmodule : tb_top

`default_nettype wire
